// ### bench/rrbs_framer_model.sv
// Behavioural receive framer delivering signaling samples and boundaries.
`timescale 1ns/1ns
`default_nettype none
module rrbs_framer_model (
   // Clock
   input wire logic ref_clk,
   // Samples towards the store
   output var logic sig_valid,
   output var logic [4:0] sig_slot,
   output var logic [3:0] sig_abcd,
   output var logic superframe_start
);
   initial begin
      sig_valid = 1'b0;
      sig_slot = 5'h00;
      sig_abcd = 4'h0;
      superframe_start = 1'b0;
   end
   // Idle lines show the inverse so nothing can ride on a stale sample.
   task automatic send(input logic [4:0] slot, input logic [3:0] abcd);
      sig_valid <= 1'b1;
      sig_slot <= slot;
      sig_abcd <= abcd;
      @(posedge ref_clk);
      sig_valid <= 1'b0;
      sig_slot <= ~slot;
      sig_abcd <= ~abcd;
   endtask
   task automatic boundary();
      superframe_start <= 1'b1;
      @(posedge ref_clk);
      superframe_start <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### bench/rrbs_store_bench.sv
// Self-checking bench for the receive signaling store.
`timescale 1ns/1ns
`default_nettype none
`include "rrbs_map.vh"
`define BCHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module rrbs_store_bench;
   localparam NCH = 24;
   logic ref_clk, reset_n, reg_wr, reg_rd;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, v, r, x, sch;
   wire [7:0] reg_rdata;
   wire sig_valid, superframe_start, out_valid;
   wire [4:0] sig_slot, out_slot;
   wire [3:0] sig_abcd, out_abcd;
   int num_errors, n_tests, i, ch;
   logic [31:0] seed = 32'h59b6;
   logic [3:0] snap_m [0:23];
   logic [3:0] sub_m [0:23];
   rrbs_store #(.NCH(NCH)) u_rrbs_store (.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sig_valid(sig_valid),
      .sig_slot(sig_slot), .sig_abcd(sig_abcd),
      .superframe_start(superframe_start), .out_valid(out_valid),
      .out_slot(out_slot), .out_abcd(out_abcd));
   rrbs_framer_model u_rrbs_framer_model (.ref_clk(ref_clk),
      .sig_valid(sig_valid), .sig_slot(sig_slot), .sig_abcd(sig_abcd),
      .superframe_start(superframe_start));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [3:0] sub_f(logic [7:0] s, logic [3:0] v, rx);
      if (!s[4]) return rx;
      case (s[3:2])
         2'h0: return 4'hf;
         2'h1: return v;
         2'h2: return {v[3:2], rx[1:0]};
         default: return {v[3], rx[2:0]};
      endcase
   endfunction
   function automatic logic [3:0] ext_f(logic [7:0] s, logic [3:0] o, rx);
      case (s[1:0])
         2'h0: return o;
         2'h1: return rx;
         2'h2: return {rx[3:2], 2'h0};
         default: return {rx[3], 3'h0};
      endcase
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      foreach (snap_m[k]) snap_m[k] = 4'h0;
   endtask
   task automatic wr(logic [11:0] a, logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      // One idle edge so a following call never re-raises the strobe at once.
      @(posedge ref_clk);
   endtask
   task automatic rd(logic [11:0] a, logic [7:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      `BCHK("reg_rdata", e, reg_rdata)
      @(posedge ref_clk);
   endtask
   task automatic smp(logic [4:0] s, logic [3:0] a, e, logic ok);
      u_rrbs_framer_model.send(s, a);
      @(posedge ref_clk);
      @(negedge ref_clk);
      `BCHK("out_valid", ok, out_valid)
      if (ok) `BCHK("out_abcd", e, out_abcd)
      if (ok) `BCHK("out_slot", s, out_slot)
      @(posedge ref_clk);
   endtask
   task automatic dbn(logic [3:0] a, b, e);
      smp(5'h14, a, a, 1'b1);
      rd(`RRBS_SNAP_BASE + 12'h14, {4'h0, b});
      u_rrbs_framer_model.boundary();
      repeat (2) @(posedge ref_clk);
      rd(`RRBS_SNAP_BASE + 12'h14, {4'h0, e});
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk);
      num_errors++;
      $display("unexpected timeout exp done got hang");
      results();
   end
   initial begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      @(posedge ref_clk);
      do_reset();
      for (i = 0; i < NCH; i++) begin
         rd(`RRBS_SUB_BASE + 12'(i), 8'h00);
         rd(`RRBS_SNAP_BASE + 12'(i), 8'h00);
      end
      $display("test reset values done");
      for (i = 0; i < NCH; i++) begin
         v = 8'(rnd());
         sub_m[i] = v[3:0];
         wr(`RRBS_SUB_BASE + 12'(i), v);
         wr(`RRBS_SNAP_BASE + 12'(i), ~v);
         rd(`RRBS_SUB_BASE + 12'(i), {4'h0, v[3:0]});
         rd(`RRBS_SNAP_BASE + 12'(i), 8'h00);
      end
      rd(`RRBS_SUB_BASE + 12'(NCH), 8'h00);
      $display("test register access done");
      for (i = 0; i < 32; i++) begin
         r = 8'(rnd());
         x = 8'(rnd());
         ch = int'(r[4:0]) % NCH;
         sch = {3'h0, 5'(i)};
         wr(`RRBS_FRAMER_CTRL, {x[7], ~x[7] & x[6], 6'h00});
         wr(`RRBS_SCHEME_BASE + 12'(ch), sch);
         rd(`RRBS_FRAMER_CTRL, {x[7], ~x[7] & x[6], 6'h00});
         rd(`RRBS_SCHEME_BASE + 12'(ch), sch);
         v = {4'h0, sub_f(sch, sub_m[ch], r[7:4])};
         smp(5'(ch), r[7:4], v[3:0], 1'b1);
         `BCHK("out_abcd held", v[3:0], out_abcd)
         snap_m[ch] = ext_f(sch, snap_m[ch], r[7:4]);
         v = {4'h0, snap_m[ch]};
         rd(`RRBS_SNAP_BASE + 12'(ch), v);
      end
      smp(5'h18 | 5'(x[2:0]), 4'h5, 4'h0, 1'b0);
      $display("test substitution and extraction done");
      do_reset();
      wr(`RRBS_FRAMER_CTRL, 8'hc0);
      wr(`RRBS_SCHEME_BASE + 12'h14, 8'h01);
      x = 8'(rnd()) | 8'h08;
      dbn(x[3:0], 4'h0, 4'h0);
      dbn(x[3:0], 4'h0, x[3:0]);
      dbn(~x[3:0], x[3:0], x[3:0]);
      dbn(x[3:0], x[3:0], x[3:0]);
      $display("test debounce done");
      results();
   end
endmodule
`default_nettype wire

// ### bench/rrbs_store_sva.sv
// Port checker for the receive signaling store.
`timescale 1ns/1ns
`default_nettype none
module rrbs_store_chk #(
   parameter NCH = 24
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Framer side
   input wire logic sig_valid,
   input wire logic [4:0] sig_slot,
   input wire logic out_valid,
   input wire logic [4:0] out_slot,
   input wire logic [3:0] out_abcd
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_take;
      sig_valid && sig_slot < NCH;
   endsequence
   sequence s_drop;
      sig_valid && sig_slot >= NCH;
   endsequence
   chk_out_latency: assert property (s_take |-> ##2 out_valid)
      else $error("Sample not answered two cycles later.");
   chk_out_cause: assert property (out_valid |->
      $past(sig_valid, 2) && $past(sig_slot, 2) < NCH)
      else $error("Output pulse without a sample.");
   chk_slot_echo: assert property (
      s_take ##2 out_valid |-> out_slot == $past(sig_slot, 2))
      else $error("Output slot differs from sample slot.");
   chk_drop_slot: assert property (s_drop |-> ##2 !out_valid)
      else $error("Slot beyond channel count answered.");
   chk_out_hold: assert property (
      !out_valid |-> $stable(out_abcd) && $stable(out_slot))
      else $error("Output changed without a pulse.");
   chk_rd_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("Read data outside the answer cycle.");
   chk_rsvd_zero: assert property ($past(reg_rd) &&
      ($past(reg_addr) - 12'h3c0 < NCH || $past(reg_addr) - 12'h500 < NCH)
      |-> reg_rdata[7:4] == 4'h0)
      else $error("Reserved bits read nonzero.");
   chk_unmapped: assert property (
      $past(reg_rd) && $past(reg_addr) == 12'h3c0 + NCH |-> reg_rdata == 8'h00)
      else $error("Unmapped address read nonzero.");
   chk_reset_quiet: assert property (
      $rose(reset_n) |-> !out_valid && reg_rdata == 8'h00)
      else $error("Outputs active right after reset.");
endmodule
bind rrbs_store rrbs_store_chk #(.NCH(NCH)) u_rrbs_store_chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sig_valid(sig_valid),
   .sig_slot(sig_slot), .out_valid(out_valid), .out_slot(out_slot),
   .out_abcd(out_abcd));
`default_nettype wire

// ### rtl/rrbs_map.vh
// Register offsets, field positions, reset values and counts of the signaling store.
`ifndef RRBS_MAP_VH
`define RRBS_MAP_VH

// ***********************************************************
// Register offsets (12-bit register port address)
// ***********************************************************
`define RRBS_FRAMER_CTRL 12'h107
`define RRBS_SCHEME_BASE 12'h3a0
`define RRBS_SUB_BASE 12'h3c0
`define RRBS_SNAP_BASE 12'h500

// ***********************************************************
// Field positions
// ***********************************************************
`define RRBS_CTRL_BOUNDARY_BIT 7
`define RRBS_CTRL_DEBOUNCE_BIT 6
`define RRBS_SCH_SUB_EN_BIT 4
`define RRBS_SCH_SUB_HI 3
`define RRBS_SCH_SUB_LO 2
`define RRBS_SCH_EXT_HI 1
`define RRBS_SCH_EXT_LO 0
`define RRBS_BIT_A 3
`define RRBS_BIT_B 2
`define RRBS_BIT_C 1
`define RRBS_BIT_D 0

// ***********************************************************
// Codes, reset values and counts
// ***********************************************************
`define RRBS_SCHEME_ALL_ONES 2'h0
`define RRBS_SCHEME_16 2'h1
`define RRBS_SCHEME_4 2'h2
`define RRBS_SCHEME_2 2'h3
`define RRBS_SUB_RESET 4'h0
`define RRBS_SNAP_RESET 4'h0
`define RRBS_SCHEME_RESET 5'h00
`define RRBS_CTRL_RESET 2'h0
`define RRBS_DEBOUNCE_SF 2'h2

`endif

// ### rtl/rrbs_mem.v
// Small register-file memory with one write port and two registered read ports.
`timescale 1ns/1ns
`default_nettype none

module rrbs_mem #(
   parameter W = 4,
   parameter D = 24,
   parameter AW = 5
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [W-1:0] wr_data,
   // Read port A
   input wire [AW-1:0] ra_addr,
   output reg [W-1:0] ra_data,
   // Read port B
   input wire [AW-1:0] rb_addr,
   output reg [W-1:0] rb_data
);

   reg [W-1:0] mem [0:D-1];
   integer i;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (i = 0; i < D; i = i + 1) begin
            mem[i] <= {W{1'b0}};
         end
         ra_data <= {W{1'b0}};
         rb_data <= {W{1'b0}};
      end else begin
         if (wr_en && wr_addr < D) begin
            mem[wr_addr] <= wr_data;
         end
         // An address beyond the depth reads as zero.
         ra_data <= (ra_addr < D) ? mem[ra_addr] : {W{1'b0}};
         rb_data <= (rb_addr < D) ? mem[rb_addr] : {W{1'b0}};
      end
   end

endmodule

`default_nettype wire

// ### rtl/rrbs_store.v
// Receive signaling substitution values, schemes and debounced snapshot store.
`timescale 1ns/1ns
`default_nettype none
`include "rrbs_map.vh"

// Contract
// - One substitution value register per receive channel, consecutive addresses.
// - Bit 3 replaces received A under 16-, 4- or 2-code substitution.
// - Bit 2 replaces received B under 16- or 4-code substitution.
// - Bit 1 replaces received C only under 16-code substitution.
// - Bit 0 replaces received D only under 16-code substitution.
// - Substitution bits are read/write and clear at reset; bits 7-4 reserved.
// - Read-only snapshot per timeslot: A bit 3, B bit 2, C bit 1, D bit 0.
// - Debounce updates snapshot after signaling equal for two superframes.
// - Debounce keeps the old snapshot when consecutive superframes differ.
// - Boundary control bit 7 and debounce bit 6 both set: snapshot changes only on superframe boundary.
// - Debounce off or boundary bit clear: snapshot follows changes at once.
// - Scheme 00 all ones, 01 A-D, 10 A-B, 11 A only.
// - Extraction 00 none, 01 A-D, 10 A-B, 11 A only.
module rrbs_store #(
   parameter NCH = 24
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Register port
   input wire [11:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   // Received signaling from the framer
   input wire sig_valid,
   input wire [4:0] sig_slot,
   input wire [3:0] sig_abcd,
   input wire superframe_start,
   // Signaling after substitution
   output reg out_valid,
   output reg [4:0] out_slot,
   output reg [3:0] out_abcd
);

   localparam [5:0] nch_w = NCH[5:0];
   localparam [2:0] sel_none = 3'h0;
   localparam [2:0] sel_sub = 3'h1;
   localparam [2:0] sel_sch = 3'h2;
   localparam [2:0] sel_snap = 3'h3;
   localparam [2:0] sel_ctrl = 3'h4;

   // ***********************************************************
   // Register decode
   // ***********************************************************
   wire [11:0] blk = {reg_addr[11:5], 5'h00};
   wire [4:0] idx = reg_addr[4:0];
   wire in_range = {1'b0, idx} < nch_w;
   wire hit_sub = (blk == `RRBS_SUB_BASE) && in_range;
   wire hit_sch = (blk == `RRBS_SCHEME_BASE) && in_range;
   wire hit_snap = (blk == `RRBS_SNAP_BASE) && in_range;
   wire hit_ctrl = (reg_addr == `RRBS_FRAMER_CTRL);

   reg boundary_mode;
   reg debounce_en;
   reg [2:0] rd_sel;
   reg [3:0] snap_rd;
   reg [7:0] next_rdata;

   // ***********************************************************
   // Framer control bits
   // ***********************************************************
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         boundary_mode <= 1'b0;
         debounce_en <= 1'b0;
      end else if (reg_wr && hit_ctrl) begin
         boundary_mode <= reg_wdata[`RRBS_CTRL_BOUNDARY_BIT];
         debounce_en <= reg_wdata[`RRBS_CTRL_DEBOUNCE_BIT];
      end
   end

   // ***********************************************************
   // Per-channel memories
   // ***********************************************************
   wire [3:0] sub_host;
   wire [3:0] sub_path;
   wire [4:0] sch_host;
   wire [4:0] sch_path;

   // Only the low nibble is stored; upper bits vanish on write.
   rrbs_mem #(.W(4), .D(NCH), .AW(5)) u_sub_mem (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wr_en(reg_wr && hit_sub),
      .wr_addr(idx),
      .wr_data(reg_wdata[3:0]),
      .ra_addr(idx),
      .ra_data(sub_host),
      .rb_addr(sig_slot),
      .rb_data(sub_path)
   );

   rrbs_mem #(.W(5), .D(NCH), .AW(5)) u_sch_mem (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wr_en(reg_wr && hit_sch),
      .wr_addr(idx),
      .wr_data(reg_wdata[4:0]),
      .ra_addr(idx),
      .ra_data(sch_host),
      .rb_addr(sig_slot),
      .rb_data(sch_path)
   );

   // ***********************************************************
   // Datapath stage 1: the sample waits for its channel settings
   // ***********************************************************
   reg s1_valid;
   reg [4:0] s1_slot;
   reg [3:0] s1_abcd;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_valid <= 1'b0;
         s1_slot <= 5'h00;
         s1_abcd <= 4'h0;
      end else begin
         s1_valid <= sig_valid && ({1'b0, sig_slot} < nch_w);
         s1_slot <= sig_slot;
         s1_abcd <= sig_abcd;
      end
   end

   // ***********************************************************
   // Substitution
   // ***********************************************************
   wire [1:0] sub_code = sch_path[`RRBS_SCH_SUB_HI:`RRBS_SCH_SUB_LO];
   wire [1:0] ext_code = sch_path[`RRBS_SCH_EXT_HI:`RRBS_SCH_EXT_LO];
   reg [3:0] next_abcd;

   always @* begin
      next_abcd = s1_abcd;
      if (sch_path[`RRBS_SCH_SUB_EN_BIT]) begin
         case (sub_code)
            `RRBS_SCHEME_ALL_ONES: begin
               next_abcd = 4'hf;
            end
            `RRBS_SCHEME_16: begin
               next_abcd[`RRBS_BIT_A] = sub_path[`RRBS_BIT_A];
               next_abcd[`RRBS_BIT_B] = sub_path[`RRBS_BIT_B];
               next_abcd[`RRBS_BIT_C] = sub_path[`RRBS_BIT_C];
               next_abcd[`RRBS_BIT_D] = sub_path[`RRBS_BIT_D];
            end
            `RRBS_SCHEME_4: begin
               next_abcd[`RRBS_BIT_A] = sub_path[`RRBS_BIT_A];
               next_abcd[`RRBS_BIT_B] = sub_path[`RRBS_BIT_B];
            end
            default: begin
               next_abcd[`RRBS_BIT_A] = sub_path[`RRBS_BIT_A];
            end
         endcase
      end
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         out_slot <= 5'h00;
         out_abcd <= 4'h0;
      end else begin
         out_valid <= s1_valid;
         if (s1_valid) begin
            out_slot <= s1_slot;
            out_abcd <= next_abcd;
         end
      end
   end

   // ***********************************************************
   // Extraction and snapshot
   // ***********************************************************
   reg [3:0] ext_mask;

   always @* begin
      case (ext_code)
         `RRBS_SCHEME_ALL_ONES: ext_mask = 4'h0;
         `RRBS_SCHEME_16: ext_mask = 4'hf;
         `RRBS_SCHEME_4: ext_mask = 4'hc;
         default: ext_mask = 4'h8;
      endcase
   end

   wire [3:0] ext_abcd = s1_abcd & ext_mask;
   wire ext_take = s1_valid && (ext_code != `RRBS_SCHEME_ALL_ONES);
   // Debounce only gates updates while boundary mode is also on.
   wire immediate = !(debounce_en && boundary_mode);

   reg [3:0] snap [0:NCH-1];
   reg [3:0] cur [0:NCH-1];
   reg [3:0] last [0:NCH-1];
   reg [1:0] stable [0:NCH-1];
   integer i;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (i = 0; i < NCH; i = i + 1) begin
            snap[i] <= `RRBS_SNAP_RESET;
            cur[i] <= `RRBS_SNAP_RESET;
            last[i] <= `RRBS_SNAP_RESET;
            stable[i] <= 2'h0;
         end
      end else begin
         // Boundary work uses the values of the closing superframe.
         if (superframe_start) begin
            for (i = 0; i < NCH; i = i + 1) begin
               // The count saturates so a long quiet line cannot wrap.
               if (cur[i] == last[i]) begin
                  if (stable[i] != 2'h3) begin
                     stable[i] <= stable[i] + 2'h1;
                  end
               end else begin
                  stable[i] <= 2'h1;
               end
               last[i] <= cur[i];
               // Unequal superframes leave the snapshot as it was.
               if (!immediate && cur[i] == last[i] &&
                   stable[i] >= `RRBS_DEBOUNCE_SF - 2'h1) begin
                  snap[i] <= cur[i];
               end
            end
         end
         // A sample in the boundary cycle belongs to the new superframe.
         if (ext_take) begin
            cur[s1_slot] <= ext_abcd;
            if (immediate) begin
               snap[s1_slot] <= ext_abcd;
            end
         end
      end
   end

   // ***********************************************************
   // Read back: data stand in the cycle after the strobe only
   // ***********************************************************
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_sel <= sel_none;
         snap_rd <= 4'h0;
      end else begin
         snap_rd <= hit_snap ? snap[idx] : 4'h0;
         if (!reg_rd) begin
            rd_sel <= sel_none;
         end else if (hit_sub) begin
            rd_sel <= sel_sub;
         end else if (hit_sch) begin
            rd_sel <= sel_sch;
         end else if (hit_snap) begin
            rd_sel <= sel_snap;
         end else if (hit_ctrl) begin
            rd_sel <= sel_ctrl;
         end else begin
            rd_sel <= sel_none;
         end
      end
   end

   // Upper nibble of value and snapshot registers reads zero.
   always @* begin
      case (rd_sel)
         sel_sub: next_rdata = {4'h0, sub_host};
         sel_sch: next_rdata = {3'h0, sch_host};
         sel_snap: next_rdata = {4'h0, snap_rd};
         sel_ctrl: next_rdata = {boundary_mode, debounce_en, 6'h00};
         default: next_rdata = 8'h00;
      endcase
   end

   assign reg_rdata = next_rdata;

endmodule

`default_nettype wire
